// ===== logic/apls_pkg.sv
// package for the active pass-through local bus sequencer
// assumes a single 10 MHz clock domain shared with the target core
package apls_pkg;

	localparam int APLS_CLK_MHZ = 10;
	localparam logic [1:0] APLS_REG_CTRL = 2'h0;
	localparam logic [1:0] APLS_REG_STATUS = 2'h1;
	localparam logic [31:0] APLS_CTRL_RESET = 32'h0000_0000;
	localparam int APLS_FIELD_W = 8;
	localparam int APLS_WS_LSB = 0;
	localparam int APLS_WS_W = 3;
	localparam int APLS_WIDTH_LSB = 4;
	localparam int APLS_ENDIAN_BIT = 6;
	localparam int APLS_ADDR_EN_BIT = 7;
	localparam logic [3:0] APLS_BE_NONE = 4'hF;

	typedef enum logic [1:0] {
		APLS_BUS32,
		APLS_BUS16,
		APLS_BUS8,
		APLS_BUSRSV
	} apls_width_e;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0] be_n;
		logic [1:0] region;
		logic write;
		logic last;
	} apls_req_s;

	typedef struct packed {
		logic addr_en;
		logic big_endian;
		apls_width_e width;
		logic [2:0] wait_states;
	} apls_region_s;

endpackage : apls_pkg

// ===== logic/apls_sequencer.sv
// active mode pass-through local bus sequencer
// assumes the target core holds req until req_ready and add-on logic shares clk_in
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module apls_sequencer import apls_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic [1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	input wire logic req_valid_in,
	input wire apls_req_s req_in,
	output logic req_ready_out,
	output logic [31:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic interface_mode_strap_in,
	input wire logic addon_wait_request_n_in,
	input wire logic [31:0] dq_in,
	output logic [31:0] dq_out,
	output logic dq_oe_out,
	output logic transfer_attention_n_out,
	output logic address_cycle_strobe_n_out,
	output logic transfer_strobe_n_out,
	output logic burst_flag_n_out,
	output logic [3:0] region_byte_enables_n_out,
	output logic [1:0] region_number_out,
	output logic write_direction_out
);

	typedef enum logic [2:0] {
		S_IDLE,
		S_ATTN,
		S_ADDR,
		S_DATA,
		S_STROBE,
		S_DONE
	} apls_state_e;

	apls_state_e state_q;
	logic [31:0] ctrl_q;
	apls_req_s cur_q;
	logic [2:0] wcnt_q;
	logic [1:0] part_q;
	logic active;
	logic wait_ok;
	apls_region_s reg_sel;
	logic [1:0] parts_last;
	logic [31:0] lane_data;
	// next-strobe selection: in the strobe state it looks one part ahead, or to the next item after the last part
	logic in_strobe;
	logic adv_part;
	logic more;
	logic decide;
	logic [2:0] wcnt_now;
	logic [1:0] sel_part;
	logic [31:0] sel_data;
	logic sel_last;
	logic strobe_go;
	logic final_strobe;

	function automatic apls_region_s region_field(input logic [31:0] c, input logic [1:0] r);
		logic [7:0] f;
		f = c[r*APLS_FIELD_W +: APLS_FIELD_W];
		region_field.addr_en = f[APLS_ADDR_EN_BIT];
		region_field.big_endian = f[APLS_ENDIAN_BIT];
		region_field.width = apls_width_e'(f[APLS_WIDTH_LSB +: 2]);
		region_field.wait_states = f[APLS_WS_LSB +: APLS_WS_W];
	endfunction : region_field

	// byte steering for one part of the word
	function automatic logic [31:0] steer(input logic [31:0] d, input apls_region_s rf,
			input logic [1:0] p);
		logic [7:0] b0;
		logic [7:0] b1;
		steer = d;
		b0 = d[{p, 3'h0} +: 8];
		b1 = d[{p[0], 4'h0} +: 8];
		unique case (rf.width)
			APLS_BUS16: begin
				if (rf.big_endian) begin
					steer = {16'h0000, d[{p[0], 4'h0} +: 8], d[{p[0], 4'h8} +: 8]};
				end else begin
					steer = {16'h0000, d[{p[0], 4'h8} +: 8], b1};
				end
			end
			APLS_BUS8: steer = {24'h000000, b0};
			default: begin
				if (rf.big_endian) begin
					steer = {d[7:0], d[15:8], d[23:16], d[31:24]};
				end
			end
		endcase
	endfunction : steer

	assign active = ~interface_mode_strap_in;
	assign wait_ok = addon_wait_request_n_in;
	assign reg_sel = region_field(ctrl_q, cur_q.region);
	assign parts_last = (reg_sel.width == APLS_BUS16) ? 2'h1 :
		(reg_sel.width == APLS_BUS8) ? 2'h3 : 2'h0;
	assign lane_data = steer(sel_data, reg_sel, sel_part);
	assign req_ready_out = (state_q == S_IDLE) && active;

	////////////////////////////////////////////////////////////////////////
	// register port

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q <= APLS_CTRL_RESET;
		end else if (clk_en_in && reg_write_in && reg_addr_in == APLS_REG_CTRL) begin
			ctrl_q <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (clk_en_in) begin
			if (reg_read_in && reg_addr_in == APLS_REG_CTRL) begin
				reg_rdata_out <= ctrl_q;
			end else if (reg_read_in && reg_addr_in == APLS_REG_STATUS) begin
				reg_rdata_out <= {24'h000000, 2'h0, part_q, 1'b0, 3'(state_q)};
			end else begin
				reg_rdata_out <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= S_IDLE;
			cur_q <= '0;
			wcnt_q <= 3'h0;
			part_q <= 2'h0;
		end else if (clk_en_in) begin
			unique case (state_q)
				S_IDLE: begin
					if (req_valid_in && active) begin
						cur_q <= req_in;
						part_q <= 2'h0;
						state_q <= S_ATTN;
					end
				end
				S_ATTN: begin
					wcnt_q <= 3'h0;
					if (wait_ok) begin
						if (reg_sel.addr_en) begin
							state_q <= S_ADDR;
						end else if (strobe_go) begin
							state_q <= S_STROBE;
						end else begin
							// the next cycle is the first programmed wait
							wcnt_q <= 3'h1;
							state_q <= S_DATA;
						end
					end
				end
				S_ADDR: begin
					state_q <= S_DATA;
					if (!cur_q.write) begin
						// read turnaround is the first wait state when any are programmed
						wcnt_q <= (reg_sel.wait_states != 3'h0) ? 3'h1 : 3'h0;
					end else if (strobe_go) begin
						state_q <= S_STROBE;
					end else if (wait_ok) begin
						wcnt_q <= 3'h1;
					end
				end
				S_DATA: begin
					if (wait_ok) begin
						if (strobe_go) begin
							state_q <= S_STROBE;
						end else begin
							wcnt_q <= wcnt_q + 3'h1;
						end
					end
				end
				S_STROBE: begin
					wcnt_q <= 3'h0;
					if (more) begin
						part_q <= sel_part;
						if (!adv_part) begin
							cur_q <= req_in;
						end
						if (strobe_go) begin
							// zero waits: strobes follow back to back
							state_q <= S_STROBE;
						end else begin
							if (wait_ok) begin
								wcnt_q <= 3'h1;
							end
							state_q <= S_DATA;
						end
					end else begin
						state_q <= S_DONE;
					end
				end
				S_DONE: state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers

	// every edge that chooses between a strobe and a wait for the next cycle
	assign in_strobe = (state_q == S_STROBE);
	assign adv_part = (part_q != parts_last);
	assign more = adv_part || (!cur_q.last && req_valid_in);
	assign decide = wait_ok && ((state_q == S_ATTN && !reg_sel.addr_en) ||
		(state_q == S_ADDR && cur_q.write) || state_q == S_DATA || (in_strobe && more));
	assign wcnt_now = (state_q == S_DATA) ? wcnt_q : 3'h0;
	assign strobe_go = decide && (wcnt_now >= reg_sel.wait_states);
	assign sel_part = !in_strobe ? part_q : (adv_part ? part_q + 2'h1 : 2'h0);
	assign sel_data = (in_strobe && !adv_part) ? req_in.data : cur_q.data;
	assign sel_last = (in_strobe && !adv_part) ? req_in.last : cur_q.last;
	assign final_strobe = (sel_part == parts_last) && sel_last;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			transfer_attention_n_out <= 1'b1;
			address_cycle_strobe_n_out <= 1'b1;
			transfer_strobe_n_out <= 1'b1;
			burst_flag_n_out <= 1'b1;
			dq_oe_out <= 1'b0;
			dq_out <= 32'h0000_0000;
			region_byte_enables_n_out <= APLS_BE_NONE;
			region_number_out <= 2'h0;
			write_direction_out <= 1'b0;
		end else if (clk_en_in) begin
			address_cycle_strobe_n_out <= 1'b1;
			transfer_strobe_n_out <= 1'b1;
			dq_oe_out <= 1'b0;
			if (state_q == S_IDLE && req_valid_in && active) begin
				transfer_attention_n_out <= 1'b0;
				burst_flag_n_out <= req_in.last;
				region_byte_enables_n_out <= req_in.be_n;
				region_number_out <= req_in.region;
				write_direction_out <= req_in.write;
			end
			if (state_q == S_ATTN && wait_ok && reg_sel.addr_en) begin
				address_cycle_strobe_n_out <= 1'b0;
				dq_out <= cur_q.addr;
				dq_oe_out <= 1'b1;
			end
			if (strobe_go) begin
				transfer_strobe_n_out <= 1'b0;
				dq_out <= lane_data;
				dq_oe_out <= cur_q.write;
				if (final_strobe) begin
					transfer_attention_n_out <= 1'b1;
				end
			end
			if (state_q == S_STROBE && part_q == parts_last && !cur_q.last && req_valid_in) begin
				region_byte_enables_n_out <= req_in.be_n;
				burst_flag_n_out <= req_in.last;
			end
			if (state_q == S_DONE || (in_strobe && !more)) begin
				region_byte_enables_n_out <= APLS_BE_NONE;
				transfer_attention_n_out <= 1'b1;
				burst_flag_n_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= 32'h0000_0000;
			rd_valid_out <= 1'b0;
		end else if (clk_en_in) begin
			rd_valid_out <= 1'b0;
			if (state_q == S_STROBE && !cur_q.write) begin
				rd_data_out <= dq_in;
				rd_valid_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_addr_one_clock;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && !address_cycle_strobe_n_out |=> address_cycle_strobe_n_out;
	endproperty
	a_addr_one_clock: assert property (p_addr_one_clock) else $error("addr strobe too long");

	property p_wait_release;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && !addon_wait_request_n_in |=> !dq_oe_out && transfer_strobe_n_out;
	endproperty
	a_wait_release: assert property (p_wait_release) else $error("bus driven after wait");

	property p_no_strobe_idle;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && state_q == S_IDLE |=> address_cycle_strobe_n_out;
	endproperty
	a_no_strobe_idle: assert property (p_no_strobe_idle) else $error("strobe from idle");

	property p_be_after_end;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && state_q == S_DONE |=> region_byte_enables_n_out == APLS_BE_NONE;
	endproperty
	a_be_after_end: assert property (p_be_after_end) else $error("enables not released");

	property p_passive_hold;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && interface_mode_strap_in && state_q == S_IDLE |=>
			state_q == S_IDLE && transfer_attention_n_out;
	endproperty
	a_passive_hold: assert property (p_passive_hold) else $error("access in passive mode");

	property p_wait_pause;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && state_q == S_DATA && !addon_wait_request_n_in |=>
			state_q == S_DATA && wcnt_q == $past(wcnt_q);
	endproperty
	a_wait_pause: assert property (p_wait_pause) else $error("wait counter ran");

	property p_programmed_wait;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && state_q == S_DATA && wcnt_q < reg_sel.wait_states |=>
			transfer_strobe_n_out;
	endproperty
	a_programmed_wait: assert property (p_programmed_wait) else $error("strobe too early");

	property p_turnaround;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && state_q == S_ADDR && !cur_q.write |=> transfer_strobe_n_out && !dq_oe_out;
	endproperty
	a_turnaround: assert property (p_turnaround) else $error("no read turnaround");

	property p_no_addr_off;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && state_q == S_ATTN && !reg_sel.addr_en |=> address_cycle_strobe_n_out;
	endproperty
	a_no_addr_off: assert property (p_no_addr_off) else $error("addr strobe while off");

	property p_attn_start;
		@(posedge clk_in) disable iff (rst_in)
		clk_en_in && state_q == S_IDLE && req_valid_in && active |=>
			!transfer_attention_n_out && region_number_out == $past(req_in.region);
	endproperty
	a_attn_start: assert property (p_attn_start) else $error("access start pins wrong");

endmodule : apls_sequencer

// ===== sim/apls_addon_model.sv
// add-on side model: wait requests, write data capture, read data source
// assumes it shares clk_in with the sequencer and that the bench sets stall_in
`timescale 1ns/100ps
module apls_addon_model #(
	parameter logic [31:0] RD_WORD = 32'hA5C3_0F96
) (
	input wire logic clk_in,
	input wire logic stall_in,
	input wire logic write_in,
	input wire logic strobe_n_in,
	input wire logic oe_in,
	input wire logic [31:0] dq_out_in,
	output logic wait_n_out,
	output logic [31:0] dq_out
);
	logic [31:0] got[$];
	assign wait_n_out = !stall_in;
	// released bus on writes shows the inverse, never a stale copy
	assign dq_out = oe_in ? dq_out_in : (write_in ? ~dq_out_in : RD_WORD);
	always @(posedge clk_in) begin
		if (!strobe_n_in && write_in) begin
			got.push_back(dq_out);
		end
	end
endmodule : apls_addon_model

// ===== sim/tb_top.sv
// testbench for the active pass-through local bus sequencer
// assumes one 10 MHz clock, active mode strap except for one passive mode check, and the add-on model on the far side
`timescale 1ns/100ps
module tb_top import apls_pkg::*;;
	localparam logic [31:0] DW = 32'h1122_3344;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [1:0] reg_addr = 2'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, rd_data, dq_out, dq_in;
	logic req_valid = 1'b0;
	apls_req_s req = '0;
	logic stall = 1'b0;
	logic strap = 1'b0;
	logic clk_en = 1'b1;
	logic req_ready, rd_valid, dq_oe, att_n, adr_n, xfr_n, burst_n, wr_dir, wait_n;
	logic [3:0] be_n;
	logic [1:0] rnum;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	always #50 clk_in = ~clk_in;
	apls_sequencer uut (.clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_wr),
		.reg_read_in(reg_rd), .reg_rdata_out(reg_rdata), .req_valid_in(req_valid),
		.req_in(req), .req_ready_out(req_ready), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .interface_mode_strap_in(strap),
		.addon_wait_request_n_in(wait_n), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe_out(dq_oe), .transfer_attention_n_out(att_n),
		.address_cycle_strobe_n_out(adr_n), .transfer_strobe_n_out(xfr_n),
		.burst_flag_n_out(burst_n), .region_byte_enables_n_out(be_n),
		.region_number_out(rnum), .write_direction_out(wr_dir));
	apls_addon_model addon (.clk_in(clk_in), .stall_in(stall), .write_in(wr_dir),
		.strobe_n_in(xfr_n), .oe_in(dq_oe), .dq_out_in(dq_out), .wait_n_out(wait_n),
		.dq_out(dq_in));
	////////////////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wr_reg(input logic [1:0] a, input logic [31:0] d);
		@(posedge clk_in);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_in);
		reg_wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [1:0] a, output logic [31:0] d);
		@(posedge clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_in);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd_reg
	function automatic logic [31:0] exp_item(input logic [7:0] f, input int k);
		case (f[5:4])
			2'h1: return f[6] ? {16'h0, DW[16*k +: 8], DW[16*k+8 +: 8]} : {16'h0, DW[16*k +: 16]};
			2'h2: return {24'h0, DW[8*k +: 8]};
			default: return f[6] ? {DW[7:0], DW[15:8], DW[23:16], DW[31:24]} : DW;
		endcase
	endfunction : exp_item
	// one single-word access; fse is the cycle of the first strobe after attention
	task automatic run(input logic [1:0] r, input logic [7:0] f, input logic w,
			input int fse, input int rel);
		int na, an, ns, fs;
		logic [31:0] av, rv, m, g;
		logic ao, la, ps, o4, wd1, at1;
		logic [3:0] bn;
		logic [1:0] rn1;
		na = 0; an = 0; ns = 0; fs = 0; av = '0; rv = '0; ao = 0; la = 0; ps = 0;
		o4 = 1; wd1 = 0; at1 = 1; bn = '0; rn1 = '0;
		wr_reg(APLS_REG_CTRL, {24'h0, f} << (8 * r));
		addon.got.delete();
		@(posedge clk_in);
		req <= '{addr: 32'h0000_1230 + r, data: DW, be_n: 4'h0, region: r, write: w, last: 1'b1};
		req_valid <= 1'b1;
		stall <= (rel > 0);
		repeat (50) begin
			#1;
			if (req_ready) break;
			@(posedge clk_in);
		end
		@(posedge clk_in);
		req_valid <= 1'b0;
		for (int n = 1; n < 25; n++) begin
			#1;
			if (n == 1) begin
				at1 = att_n;
				wd1 = wr_dir;
				rn1 = rnum;
			end
			if (!adr_n) begin
				na++;
				an = n;
				av = dq_out;
				ao = dq_oe;
			end
			if (ps) bn = be_n;
			ps = !xfr_n;
			if (!xfr_n) begin
				ns++;
				if (fs == 0) fs = n;
				la = att_n;
			end
			if (n == 4) o4 = dq_oe;
			if (rd_valid) rv = rd_data;
			@(posedge clk_in);
			if (n == rel) stall <= 1'b0;
		end
		chk("first_strobe", fse, fs);
		chk("strobes", 1 << f[5:4], ns);
		chk("attn_start", 0, at1);
		chk("direction", w, wd1);
		chk("region", r, rn1);
		chk("attn_last", 1, la);
		chk("enables_after", APLS_BE_NONE, bn);
		chk("addr_strobes", f[7], na);
		if (f[7]) begin
			chk("addr_cycle", 2, an);
			chk("addr_value", 32'h0000_1230 + r, av);
			chk("addr_oe", 1, ao);
		end
		if (rel > 0) chk("oe_in_wait", 0, o4);
		if (!w) chk("read_data", addon.RD_WORD, rv);
		m = f[5:4] == 2'h1 ? 32'h0000_FFFF : (f[5:4] == 2'h2 ? 32'h0000_00FF : 32'hFFFF_FFFF);
		for (int k = 0; w && k < (1 << f[5:4]); k++) begin
			g = (k < addon.got.size()) ? addon.got[k] : ~exp_item(f, k);
			chk("write_data", exp_item(f, k) & m, g & m);
		end
	endtask : run
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		logic [31:0] d;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		chk("reset_strobes", 3'h7, {att_n, adr_n, xfr_n});
		chk("reset_oe", 0, dq_oe);
		rd_reg(APLS_REG_CTRL, d);
		chk("ctrl_reset", APLS_CTRL_RESET, d);
		wr_reg(APLS_REG_CTRL, 32'h8765_4321);
		rd_reg(APLS_REG_CTRL, d);
		chk("ctrl_readback", 32'h8765_4321, d);
		rd_reg(2'h3, d);
		chk("unmapped", 0, d);
		rd_reg(APLS_REG_STATUS, d);
		chk("status_idle", 0, d);
		// a write with the clock enable low must not land
		clk_en <= 1'b0;
		wr_reg(APLS_REG_CTRL, 32'h0000_00FF);
		clk_en <= 1'b1;
		rd_reg(APLS_REG_CTRL, d);
		chk("ctrl_frozen", 32'h8765_4321, d);
		@(posedge clk_in);
		strap <= 1'b1;
		req <= '{addr: 32'h0, data: DW, be_n: 4'h0, region: 2'h0, write: 1'b1, last: 1'b1};
		req_valid <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1;
		chk("passive_attn", 1, att_n);
		chk("passive_ready", 0, req_ready);
		@(posedge clk_in);
		req_valid <= 1'b0;
		strap <= 1'b0;
		run(2'h0, 8'h00, 1'b1, 2, 0);
		run(2'h1, 8'h40, 1'b1, 2, 0);
		run(2'h2, 8'h50, 1'b1, 2, 0);
		run(2'h3, 8'h60, 1'b1, 2, 0);
		run(2'h1, 8'h10, 1'b1, 2, 0);
		run(2'h2, 8'h11, 1'b1, 3, 0);
		run(2'h0, 8'h87, 1'b1, 10, 0);
		run(2'h1, 8'h82, 1'b0, 5, 0);
		run(2'h2, 8'h80, 1'b0, 4, 0);
		run(2'h3, 8'h00, 1'b1, 5, 3);
		complete_run();
	end
endmodule : tb_top
